// *** include/ltsw_pkg.sv ***
// Package of opcodes, flag positions and timing for the logic/swap/wait execution unit
package ltsw_pkg;
  // Opcodes
  localparam logic [7:0] OP_SWAP_R   = 8'hF0;
  localparam logic [7:0] OP_SWAP_IR  = 8'hF1;
  localparam logic [7:0] OP_ITST_RR  = 8'h62;
  localparam logic [7:0] OP_ITST_RI  = 8'h63;
  localparam logic [7:0] OP_ITST_GG  = 8'h64;
  localparam logic [7:0] OP_ITST_GI  = 8'h65;
  localparam logic [7:0] OP_ITST_IM  = 8'h66;
  localparam logic [7:0] OP_MTST_RR  = 8'h72;
  localparam logic [7:0] OP_MTST_RI  = 8'h73;
  localparam logic [7:0] OP_MTST_GG  = 8'h74;
  localparam logic [7:0] OP_MTST_GI  = 8'h75;
  localparam logic [7:0] OP_MTST_IM  = 8'h76;
  localparam logic [7:0] OP_XOR_RR   = 8'hB2;
  localparam logic [7:0] OP_XOR_RI   = 8'hB3;
  localparam logic [7:0] OP_XOR_GG   = 8'hB4;
  localparam logic [7:0] OP_XOR_GI   = 8'hB5;
  localparam logic [7:0] OP_XOR_IM   = 8'hB6;
  localparam logic [7:0] OP_IWAIT    = 8'h3F;
  // Flag byte positions: C Z S V D H
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_D = 3;
  localparam int FLG_H = 2;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  // Timing: one CPU cycle is one ref_clk period
  localparam int CLK_NS     = 100;
  localparam int CYC_SHORT  = 4;
  localparam int CYC_LONG   = 6;
  localparam int WAIT_QUANT = 4;
  // Instruction lengths in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  // Operations
  typedef enum logic [2:0] {
    LTSW_NOP  = 3'h0,
    LTSW_SWAP = 3'h1,
    LTSW_ITST = 3'h2,
    LTSW_MTST = 3'h3,
    LTSW_XOR  = 3'h4,
    LTSW_WAIT = 3'h5
  } ltsw_op_e;
  // Core states, Gray along idle->busy->finish
  typedef enum logic [1:0] {
    LTSW_IDLE = 2'b00,
    LTSW_BUSY = 2'b01,
    LTSW_DONE = 2'b11,
    LTSW_HALT = 2'b10
  } ltsw_st_e;
endpackage

// *** include/ltsw_alu_if.sv ***
// Interface carrying operands and results between sequencer and ALU
`timescale 1ns/1ps
interface ltsw_alu_if;
  logic [2:0] op;      // Operation, ltsw_pkg::ltsw_op_e value
  logic [7:0] dst;     // Destination operand
  logic [7:0] src;     // Source operand or mask
  logic [7:0] flg_in;  // Flags before the operation
  logic [7:0] res;     // Result byte
  logic [7:0] flg_out; // Flags after the operation
  logic       wr;      // Result goes back to destination
  modport core (output op, output dst, output src, output flg_in, input res, input flg_out, input wr);
  modport alu  (input op, input dst, input src, input flg_in, output res, output flg_out, output wr);
endinterface

// *** logic/ltsw_alu.sv ***
// Combinational ALU for swap, masked tests and exclusive OR
`timescale 1ns/1ps
module ltsw_alu (
  ltsw_alu_if.alu a
);
  // ----------------------------------------
  // Result and flag computation
  // ----------------------------------------
  always_comb
  begin
    a.res     = a.dst;
    a.flg_out = a.flg_in;
    a.wr      = 1'b0;
    case (a.op)
      3'(ltsw_pkg::LTSW_SWAP):
      begin
        a.res = {a.dst[3:0], a.dst[7:4]};
        a.wr  = 1'b1;
        // Carry and overflow undefined; chosen to clear them
        a.flg_out[ltsw_pkg::FLG_C] = 1'b0;
        a.flg_out[ltsw_pkg::FLG_V] = 1'b0;
      end
      3'(ltsw_pkg::LTSW_ITST):
      begin
        a.res = ~a.dst & a.src;
        a.flg_out[ltsw_pkg::FLG_V] = 1'b0;
      end
      3'(ltsw_pkg::LTSW_MTST):
      begin
        a.res = a.dst & a.src;
        a.flg_out[ltsw_pkg::FLG_V] = 1'b0;
      end
      3'(ltsw_pkg::LTSW_XOR):
      begin
        a.res = a.dst ^ a.src;
        a.wr  = 1'b1;
        a.flg_out[ltsw_pkg::FLG_V] = 1'b0;
      end
      default:
      begin
        a.res = a.dst;
      end
    endcase
    // Zero and sign follow the result for every data operation
    if (a.op != 3'(ltsw_pkg::LTSW_NOP) && a.op != 3'(ltsw_pkg::LTSW_WAIT))
    begin
      a.flg_out[ltsw_pkg::FLG_Z] = (a.res == 8'h00);
      a.flg_out[ltsw_pkg::FLG_S] = a.res[7];
    end
  end
endmodule

// *** logic/ltsw_core.sv ***
// Execution unit for nibble swap, masked tests, exclusive OR and interrupt wait
// How it works
// - Swap exchanges nibbles; F0/F1, 4 cycles
// - Swap: Z from result, S bit7
// - Inverted test: NOT dst AND mask, flags only
// - Inverted test: Z, S set, V cleared
// - Inverted test opcodes 62 through 66
// - Mask test: dst AND mask, flags only
// - Mask test: Z, S set, V cleared
// - Mask test opcodes 72 through 76
// - Wait halts execution; DMA continues; flags kept
// - Internal or fast interrupt ends wait
// - Wait is opcode 3F, 4n cycles
// - Exclusive OR written to destination
// - Exclusive OR: Z, S set, V cleared
// - Exclusive OR opcodes B2 through B6
`timescale 1ns/1ps
module ltsw_core (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       issue,      // One-cycle pulse: new instruction present
  input  wire logic [7:0] opcode,     // Instruction byte 1
  input  wire logic [7:0] byte2,      // Instruction byte 2
  input  wire logic [7:0] byte3,      // Instruction byte 3
  input  wire logic [7:0] dst_val,    // Destination operand fetched by the register file
  input  wire logic [7:0] src_val,    // Source operand fetched by the register file
  input  wire logic [7:0] flags_in,   // Current flag register
  input  wire logic       int_req,    // Internal interrupt pending
  input  wire logic       fast_int,   // Fast interrupt pending
  output logic            busy_r,     // Instruction in progress
  output logic            done_r,     // One-cycle pulse at end of instruction
  output logic            known_r,    // Last issued opcode belonged to this unit
  output logic [1:0]      len_r,      // Byte length of last instruction
  output logic [7:0]      dst_addr_r, // Destination register address
  output logic [7:0]      src_addr_r, // Source register address or immediate
  output logic            src_imm_r,  // Source is the immediate byte
  output logic            src_ind_r,  // Source is addressed indirectly
  output logic            dst_ind_r,  // Destination is addressed indirectly
  output logic            wr_en_r,    // Write result to destination, one cycle with done
  output logic [7:0]      wr_data_r,  // Result byte
  output logic            flags_we_r, // Write flags, one cycle with done
  output logic [7:0]      flags_out_r,// New flag value
  output logic            halted_r    // CPU halted in interrupt wait; DMA may run
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  ltsw_pkg::ltsw_op_e dec_op;    // Operation of the issued opcode
  logic [3:0]         dec_cyc;   // Cycles of the issued opcode
  logic [1:0]         dec_len;   // Length of the issued opcode
  logic [1:0]         dec_mode;  // 0 rr, 1 r@r, 2 RR, 3 R@R; immediate separate
  logic               dec_imm;   // Immediate source
  logic [7:0]         lo;        // Opcode with group nibble cleared

  // Opcode table for all five instructions
  always_comb
  begin
    dec_op   = ltsw_pkg::LTSW_NOP;
    dec_cyc  = 4'(ltsw_pkg::CYC_LONG);
    dec_len  = ltsw_pkg::LEN_3;
    dec_mode = 2'h0;
    dec_imm  = 1'b0;
    lo       = {4'h0, opcode[3:0]};
    case (opcode[7:4])
      4'h6: if (lo >= 8'h02 && lo <= 8'h06) dec_op = ltsw_pkg::LTSW_ITST;
      4'h7: if (lo >= 8'h02 && lo <= 8'h06) dec_op = ltsw_pkg::LTSW_MTST;
      4'hB: if (lo >= 8'h02 && lo <= 8'h06) dec_op = ltsw_pkg::LTSW_XOR;
      default: dec_op = ltsw_pkg::LTSW_NOP;
    endcase
    if (dec_op != ltsw_pkg::LTSW_NOP)
    begin
      // Same column layout for the three two-operand groups
      case (opcode[3:0])
        4'h2: begin dec_mode = 2'h0; dec_len = ltsw_pkg::LEN_2; dec_cyc = 4'(ltsw_pkg::CYC_SHORT); end
        4'h3: begin dec_mode = 2'h1; dec_len = ltsw_pkg::LEN_2; end
        4'h4: dec_mode = 2'h2;
        4'h5: dec_mode = 2'h3;
        default: begin dec_mode = 2'h2; dec_imm = 1'b1; end
      endcase
    end
    if (opcode == ltsw_pkg::OP_SWAP_R || opcode == ltsw_pkg::OP_SWAP_IR)
    begin
      dec_op  = ltsw_pkg::LTSW_SWAP;
      dec_len = ltsw_pkg::LEN_2;
      dec_cyc = 4'(ltsw_pkg::CYC_SHORT);
    end
    if (opcode == ltsw_pkg::OP_IWAIT)
    begin
      dec_op  = ltsw_pkg::LTSW_WAIT;
      dec_len = ltsw_pkg::LEN_1;
      dec_cyc = 4'(ltsw_pkg::WAIT_QUANT);
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  ltsw_pkg::ltsw_st_e st_r;      // Present state
  ltsw_pkg::ltsw_op_e op_r;      // Latched operation
  logic [3:0]         cnt_r;     // Cycles left in this instruction or wait quantum
  logic [7:0]         dst_r;     // Latched destination operand
  logic [7:0]         src_r;     // Latched source operand
  logic [7:0]         flg_r;     // Latched flags
  logic               wake;      // Any interrupt that ends the wait
  ltsw_alu_if         alu_bus ();

  assign wake = int_req | fast_int;

  // ALU hookup
  assign alu_bus.op     = op_r;
  assign alu_bus.dst    = dst_r;
  assign alu_bus.src    = src_r;
  assign alu_bus.flg_in = flg_r;

  ltsw_alu u_alu (
    .a (alu_bus.alu)
  );

  // Latch operands and operation on issue
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      op_r  <= ltsw_pkg::LTSW_NOP;
      dst_r <= 8'h00;
      src_r <= 8'h00;
      flg_r <= ltsw_pkg::FLAGS_RST;
    end
    else if (issue && st_r == ltsw_pkg::LTSW_IDLE)
    begin
      op_r  <= dec_op;
      dst_r <= dst_val;
      src_r <= src_val;
      flg_r <= flags_in;
    end
  end

  // State machine and cycle count; wait runs in whole 4-cycle quanta
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r  <= ltsw_pkg::LTSW_IDLE;
      cnt_r <= 4'h0;
    end
    else
    begin
      case (st_r)
        ltsw_pkg::LTSW_IDLE:
          if (issue && dec_op != ltsw_pkg::LTSW_NOP)
          begin
            // Count covers issue cycle through done cycle
            st_r  <= (dec_op == ltsw_pkg::LTSW_WAIT) ? ltsw_pkg::LTSW_HALT : ltsw_pkg::LTSW_BUSY;
            cnt_r <= dec_cyc - 4'h2;
          end
        ltsw_pkg::LTSW_BUSY:
          if (cnt_r == 4'h0)
            st_r <= ltsw_pkg::LTSW_DONE;
          else
            cnt_r <= cnt_r - 4'h1;
        ltsw_pkg::LTSW_HALT:
          if (cnt_r == 4'h0)
          begin
            // Leave only at a quantum boundary, so the total is 4n
            if (wake)
              st_r <= ltsw_pkg::LTSW_DONE;
            else
              cnt_r <= 4'(ltsw_pkg::WAIT_QUANT - 1);
          end
          else
            cnt_r <= cnt_r - 4'h1;
        ltsw_pkg::LTSW_DONE:
          st_r <= ltsw_pkg::LTSW_IDLE;
        default:
          st_r <= ltsw_pkg::LTSW_IDLE;
      endcase
    end
  end

  // Operand addressing outputs, latched at issue
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      known_r    <= 1'b0;
      len_r      <= 2'h0;
      dst_addr_r <= 8'h00;
      src_addr_r <= 8'h00;
      src_imm_r  <= 1'b0;
      src_ind_r  <= 1'b0;
      dst_ind_r  <= 1'b0;
    end
    else if (issue && st_r == ltsw_pkg::LTSW_IDLE)
    begin
      known_r   <= (dec_op != ltsw_pkg::LTSW_NOP);
      len_r     <= dec_len;
      src_imm_r <= dec_imm;
      src_ind_r <= dec_mode[0] & ~dec_imm;
      dst_ind_r <= (opcode == ltsw_pkg::OP_SWAP_IR);
      if (dec_op == ltsw_pkg::LTSW_SWAP)
      begin
        dst_addr_r <= byte2;
        src_addr_r <= 8'h00;
      end
      else if (dec_len == ltsw_pkg::LEN_2)
      begin
        // Working-register forms: dst in high nibble, src in low nibble
        dst_addr_r <= {4'h0, byte2[7:4]};
        src_addr_r <= {4'h0, byte2[3:0]};
      end
      else if (dec_imm)
      begin
        dst_addr_r <= byte2;
        src_addr_r <= byte3;
      end
      else
      begin
        src_addr_r <= byte2;
        dst_addr_r <= byte3;
      end
    end
  end

  // Completion outputs; test operations never write back, wait writes nothing
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
      wr_en_r     <= 1'b0;
      wr_data_r   <= 8'h00;
      flags_we_r  <= 1'b0;
      flags_out_r <= ltsw_pkg::FLAGS_RST;
      halted_r    <= 1'b0;
    end
    else
    begin
      busy_r   <= (st_r == ltsw_pkg::LTSW_IDLE) ? (issue && dec_op != ltsw_pkg::LTSW_NOP)
                                                : (st_r != ltsw_pkg::LTSW_DONE);
      halted_r <= (st_r == ltsw_pkg::LTSW_IDLE && issue && dec_op == ltsw_pkg::LTSW_WAIT) ||
                  (st_r == ltsw_pkg::LTSW_HALT && !(cnt_r == 4'h0 && wake));
      done_r   <= (st_r == ltsw_pkg::LTSW_DONE);
      if (st_r == ltsw_pkg::LTSW_DONE)
      begin
        wr_en_r     <= alu_bus.wr;
        wr_data_r   <= alu_bus.res;
        flags_we_r  <= (op_r != ltsw_pkg::LTSW_WAIT);
        flags_out_r <= alu_bus.flg_out;
      end
      else
      begin
        wr_en_r    <= 1'b0;
        flags_we_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_issue_short;
    issue && st_r == ltsw_pkg::LTSW_IDLE && dec_cyc == 4'h4 && dec_op != ltsw_pkg::LTSW_WAIT;
  endsequence

  // done_r is launched at the fourth edge after issue, so it is sampled high one edge later
  a_short_cycles: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_issue_short |-> ##1 !done_r [*4] ##1 done_r)
    else $error("short instruction did not end after 4 cycles");

  a_long_cycles: assert property (@(posedge ref_clk) disable iff (sys_rst)
    issue && st_r == ltsw_pkg::LTSW_IDLE && dec_cyc == 4'h6 && dec_op != ltsw_pkg::LTSW_NOP
    |-> ##1 !done_r [*6] ##1 done_r)
    else $error("long instruction did not end after 6 cycles");

  a_test_nowrite: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_r && (op_r == ltsw_pkg::LTSW_MTST || op_r == ltsw_pkg::LTSW_ITST) |-> !wr_en_r)
    else $error("masked test wrote its destination");

  a_swap_result: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_r && op_r == ltsw_pkg::LTSW_SWAP |-> wr_data_r == {dst_r[3:0], dst_r[7:4]})
    else $error("swap result wrong");

  a_xor_flags: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_r && op_r == ltsw_pkg::LTSW_XOR |->
      flags_out_r[ltsw_pkg::FLG_Z] == (wr_data_r == 8'h00) && !flags_out_r[ltsw_pkg::FLG_V]
      && flags_out_r[ltsw_pkg::FLG_C] == flg_r[ltsw_pkg::FLG_C])
    else $error("xor flags wrong");

  a_itst_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_r && op_r == ltsw_pkg::LTSW_ITST |->
      flags_out_r[ltsw_pkg::FLG_Z] == ((~dst_r & src_r) == 8'h00))
    else $error("inverted test zero flag wrong");

  a_wait_noflags: assert property (@(posedge ref_clk) disable iff (sys_rst)
    done_r && op_r == ltsw_pkg::LTSW_WAIT |-> !flags_we_r && !wr_en_r)
    else $error("interrupt wait changed flags");

  a_wait_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r == ltsw_pkg::LTSW_HALT && !wake |=> st_r == ltsw_pkg::LTSW_HALT)
    else $error("wait left without interrupt");

  a_wait_wakes: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r == ltsw_pkg::LTSW_HALT && wake |-> ##[1:4] st_r == ltsw_pkg::LTSW_DONE)
    else $error("interrupt did not end the wait");

  a_wait_quantum: assert property (@(posedge ref_clk) disable iff (sys_rst)
    st_r == ltsw_pkg::LTSW_HALT && cnt_r == 4'h0 && wake |=> ##1 done_r)
    else $error("wait did not end on a quantum boundary");
endmodule

// *** verification/ltsw_rf_model.sv ***
// Register file and flag register model on the far side of the execution unit
`timescale 1ns/1ps
module ltsw_rf_model (
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,    // Result write strobe
  input  wire logic [7:0] wr_data,  // Result byte
  input  wire logic       flags_we, // Flag write strobe
  input  wire logic [7:0] flags_wd, // New flag value
  input  wire logic       load,     // Preload of the flag register
  input  wire logic [7:0] load_val, // Preload value
  output logic      [7:0] flags,    // Flag register seen by the unit
  output int              wr_cnt,   // Result writes taken
  output logic      [7:0] last_wr   // Last byte written
);
  // Flag register; a preload wins so every test starts from known flags
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      flags <= 8'h00;
    else if (load)
      flags <= load_val;
    else if (flags_we)
      flags <= flags_wd;
  end
  // Write counter shows whether a test instruction wrongly wrote back
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_cnt  <= 0;
      last_wr <= 8'h00;
    end
    else if (wr_en)
    begin
      wr_cnt  <= wr_cnt + 1;
      last_wr <= wr_data;
    end
  end
endmodule

// *** verification/test_logic_test_swap_wait_ops.sv ***
// Self-checking bench of the swap, masked test, exclusive OR and wait unit
`timescale 1ns/1ps
module test_logic_test_swap_wait_ops;
  logic       ref_clk, sys_rst, issue, int_req, fast_int, load;
  logic [7:0] opcode, byte2, byte3, dst_val, src_val, flags_in, load_val;
  logic       busy_r, done_r, known_r, src_imm_r, src_ind_r, dst_ind_r;
  logic       wr_en_r, flags_we_r, halted_r;
  logic [1:0] len_r;
  logic [7:0] dst_addr_r, src_addr_r, wr_data_r, flags_out_r, last_wr;
  int         wr_cnt, fail_count, samples_checked, cyc_cnt;
  logic [31:0] seed = 32'h0000C872; // Fixed seed 51314

  ltsw_core u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .issue(issue), .opcode(opcode),
    .byte2(byte2), .byte3(byte3), .dst_val(dst_val), .src_val(src_val), .flags_in(flags_in),
    .int_req(int_req), .fast_int(fast_int), .busy_r(busy_r), .done_r(done_r), .known_r(known_r),
    .len_r(len_r), .dst_addr_r(dst_addr_r), .src_addr_r(src_addr_r), .src_imm_r(src_imm_r),
    .src_ind_r(src_ind_r), .dst_ind_r(dst_ind_r), .wr_en_r(wr_en_r), .wr_data_r(wr_data_r),
    .flags_we_r(flags_we_r), .flags_out_r(flags_out_r), .halted_r(halted_r));
  ltsw_rf_model u_rf (.ref_clk(ref_clk), .sys_rst(sys_rst), .wr_en(wr_en_r), .wr_data(wr_data_r),
    .flags_we(flags_we_r), .flags_wd(flags_out_r), .load(load), .load_val(load_val),
    .flags(flags_in), .wr_cnt(wr_cnt), .last_wr(last_wr));

  // ----------------------------------------
  // Helpers and expectations
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // Hang guard, far above the seven hundred or so cycles the run needs
  always @(posedge ref_clk)
  begin
    cyc_cnt++;
    if (cyc_cnt == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] e_res(input logic [7:0] op, d, s);
    case (op[7:4])
      4'hF: return {d[3:0], d[7:4]};
      4'h6: return ~d & s;
      4'h7: return d & s;
      default: return d ^ s;
    endcase
  endfunction
  // Undefined swap carry and overflow are taken as cleared
  function automatic logic [7:0] e_flg(input logic [7:0] op, r, f);
    logic [7:0] g;
    g = f;
    g[ltsw_pkg::FLG_Z] = (r == 8'h00);
    g[ltsw_pkg::FLG_S] = r[7];
    g[ltsw_pkg::FLG_V] = 1'b0;
    if (op[7:4] == 4'hF)
      g[ltsw_pkg::FLG_C] = 1'b0;
    return g;
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Preload flags, then issue one instruction on the next falling edge
  task automatic start(input logic [7:0] op, f, d, s);
    load = 1'b1;
    load_val = f;
    @(negedge ref_clk);
    load = 1'b0;
    issue = 1'b1;
    opcode = op;
    byte2 = rnd();
    byte3 = rnd();
    dst_val = d;
    src_val = s;
    @(negedge ref_clk);
    issue = 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // One ALU instruction; poke re-issues while busy, which must be ignored
  task automatic run(input logic [7:0] op, d, s, input bit poke);
    logic [7:0] f, r, lo;
    logic       wr;
    int         n, w0;
    f = rnd();
    lo = {4'h0, op[3:0]};
    wr = (op[7:4] == 4'hF) || (op[7:4] == 4'hB);
    w0 = wr_cnt;
    start(op, f, d, s);
    n = 0;
    while (done_r !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
      if (n == 1)
        check("busy", {7'h0, busy_r}, 8'h01);
      issue = poke && (n == 2);
      if (poke && n == 2)
        opcode = ltsw_pkg::OP_SWAP_R;
    end
    r = e_res(op, d, s);
    check("cycles", 8'(n), (lo == 8'h2 || op[7:4] == 4'hF) ? 8'h04 : 8'h06);
    check("len", {6'h0, len_r}, (lo < 8'h4 || op[7:4] == 4'hF) ? 8'h02 : 8'h03);
    check("known", {7'h0, known_r}, 8'h01);
    check("wr_en", {7'h0, wr_en_r}, {7'h0, wr});
    if (wr)
      check("wr_data", wr_data_r, r);
    check("flags_we", {7'h0, flags_we_r}, 8'h01);
    check("flags", flags_out_r, e_flg(op, r, f));
    if (op[7:4] == 4'hF)
    begin
      check("dst_addr", dst_addr_r, byte2);
      check("dst_ind", {7'h0, dst_ind_r}, {7'h0, op[0]});
    end
    else if (lo < 8'h4)
    begin
      check("dst_addr", {4'h0, dst_addr_r[3:0]}, {4'h0, byte2[7:4]});
      check("src_addr", {4'h0, src_addr_r[3:0]}, {4'h0, byte2[3:0]});
    end
    else
    begin
      check("dst_addr", dst_addr_r, (lo == 8'h6) ? byte2 : byte3);
      check("src_addr", src_addr_r, (lo == 8'h6) ? byte3 : byte2);
    end
    if (op[7:4] != 4'hF)
    begin
      check("src_imm", {7'h0, src_imm_r}, {7'h0, lo == 8'h6});
      check("src_ind", {7'h0, src_ind_r}, {7'h0, lo == 8'h3 || lo == 8'h5});
    end
    @(negedge ref_clk);
    check("writes", 8'(wr_cnt - w0), {7'h0, wr});
    if (wr)
      check("last_wr", last_wr, r);
    check("done_pulse", {7'h0, done_r}, 8'h00);
    @(negedge ref_clk);
  endtask
  // Wait ended by a level interrupt raised after edge k
  task automatic iwait(input bit fast, input int k);
    int         n, m;
    logic [7:0] f;
    m = (k + 5) / 4;
    f = rnd();
    start(ltsw_pkg::OP_IWAIT, f, rnd(), rnd());
    n = 0;
    while (done_r !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
      if (n == 1)
        check("halted", {7'h0, halted_r}, 8'h01);
      if (n == k)
      begin
        int_req = !fast;
        fast_int = fast;
      end
    end
    check("wait_cycles", 8'(n), 8'(4 * m));
    check("wait_flags_we", {7'h0, flags_we_r}, 8'h00);
    check("wait_halted", {7'h0, halted_r}, 8'h00);
    check("wait_len", {6'h0, len_r}, 8'h01);
    int_req = 1'b0;
    fast_int = 1'b0;
    repeat (2) @(negedge ref_clk);
    // Flag register must still hold its preload after the wait
    check("wait_keep", flags_in, f);
  endtask

  initial
  begin
    sys_rst = 1'b1;
    {issue, int_req, fast_int, load} = 4'h0;
    {opcode, byte2, byte3, dst_val, src_val, load_val} = '0;
    repeat (20) @(negedge ref_clk);
    check("rst_outs", {busy_r, done_r, known_r, wr_en_r, flags_we_r, halted_r, len_r}, 8'h00);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    // Corner values: nibble swap, zero and sign outcomes
    run(8'hF0, 8'h3E, 8'h00, 1'b0);
    run(8'hF1, 8'h00, 8'h00, 1'b0);
    run(8'h62, 8'hC7, 8'h02, 1'b0);
    run(8'h72, 8'hC7, 8'h02, 1'b0);
    run(8'h76, 8'h80, 8'h80, 1'b0);
    run(8'hB2, 8'h5A, 8'h5A, 1'b0);
    // Every test and exclusive OR opcode of every form, random operands
    for (int h = 0; h < 3; h++)
      for (int l = 2; l < 7; l++)
        repeat (3) run({(h == 0) ? 4'h6 : (h == 1) ? 4'h7 : 4'hB, 4'(l)}, rnd(), rnd(), 1'b0);
    run(8'h74, rnd(), rnd(), 1'b1);
    run(8'hB6, rnd(), rnd(), 1'b1);
    // Foreign opcode must be ignored
    start(8'h00, rnd(), rnd(), rnd());
    repeat (3) @(negedge ref_clk);
    check("foreign", {6'h0, busy_r, known_r}, 8'h00);
    for (int k = 1; k < 11; k++)
      iwait(k[0], k + (rnd() % 3));
    finish_test();
  end
endmodule
